/* File: src/pwos_pkg.sv */
// Package of constants for the pressure window, offset and status registers.
// Assumes a byte-wide register port that the serial interface logic drives.
`default_nettype none

package pwos_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] THRESH_HIGH_LOW_BYTE_ADDR = 8'h46;
    localparam logic [7:0] THRESH_HIGH_HIGH_BYTE_ADDR = 8'h47;
    localparam logic [7:0] THRESH_LOW_LOW_BYTE_ADDR = 8'h48;
    localparam logic [7:0] THRESH_LOW_HIGH_BYTE_ADDR = 8'h49;
    localparam logic [7:0] USER_OFFSET_LOW_BYTE_ADDR = 8'h4c;
    localparam logic [7:0] USER_OFFSET_HIGH_BYTE_ADDR = 8'h4d;
    localparam logic [7:0] SIGNAL_PATH_STATUS_ADDR = 8'h60;

    // ------------------------------------------------------------
    // Covered register array, in storage order
    // ------------------------------------------------------------
    localparam int COV_REGS = 6;
    localparam logic [7:0] COV_ADDR [COV_REGS] = '{
        THRESH_HIGH_LOW_BYTE_ADDR, THRESH_HIGH_HIGH_BYTE_ADDR,
        THRESH_LOW_LOW_BYTE_ADDR, THRESH_LOW_HIGH_BYTE_ADDR,
        USER_OFFSET_LOW_BYTE_ADDR, USER_OFFSET_HIGH_BYTE_ADDR};
    localparam int IDX_HI_L = 0;
    localparam int IDX_HI_H = 1;
    localparam int IDX_LO_L = 2;
    localparam int IDX_LO_H = 3;
    localparam int IDX_OFS_L = 4;
    localparam int IDX_OFS_H = 5;
    localparam logic [7:0] COV_RESET = 8'h00;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int STAT_SELFTEST_PENDING = 3;
    localparam int STAT_SELFTEST_RUNNING = 2;
    localparam int STAT_COMMON_MODE_FAULT = 1;
    localparam int STAT_SELFTEST_FAULT = 0;
    localparam logic PENDING_RESET = 1'b1;

    // ------------------------------------------------------------
    // Interrupt configuration codes and path restart length in samples
    // ------------------------------------------------------------
    localparam logic [1:0] STRETCH_NONE = 2'h0;
    localparam logic [15:0] THRESH_OFF = 16'h0000;
    localparam int REINIT_SAMPLES = 4;
endpackage

`default_nettype wire

/* File: src/pwos_window_cmp.sv */
// Window comparator stage: judges one reported pressure sample.
// Assumes thresholds and sense bit are stable while samples arrive.
`timescale 1ns/1ns
`default_nettype none

module pwos_window_cmp (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Sample
    input wire logic [15:0] sample_in,
    input wire logic sample_valid_in,
    // Configuration
    input wire logic [15:0] upper_in,
    input wire logic [15:0] lower_in,
    input wire logic window_sense_in,
    // Verdict
    output logic cond_out,
    output logic cond_valid_out
);
    // State of the stage
    typedef struct packed {
        logic cond;
        logic vld;
    } pwos_cmp_state_t;

    pwos_cmp_state_t s_r;
    pwos_cmp_state_t s_nxt;
    logic hi_en;
    logic lo_en;
    logic in_window;

    // ------------------------------------------------------------
    // Compare
    // ------------------------------------------------------------
    // Next verdict from current sample
    always_comb begin
        s_nxt = s_r;
        hi_en = (upper_in != pwos_pkg::THRESH_OFF);
        lo_en = (lower_in != pwos_pkg::THRESH_OFF);
        in_window = (!lo_en || (sample_in > lower_in)) && (!hi_en || (sample_in < upper_in));
        s_nxt.vld = sample_valid_in;
        if (sample_valid_in) begin
            s_nxt.cond = (hi_en || lo_en) && (window_sense_in ? in_window : !in_window);
        end
    end

    // Register the stage
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cond_out = s_r.cond;
    assign cond_valid_out = s_r.vld;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_both_off_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
        sample_valid_in && upper_in == 16'h0000 && lower_in == 16'h0000 |=> !cond_out)
        else $error("condition raised with both thresholds off");
    chk_sense_inside: assert property (@(posedge clk_in) disable iff (rst_in)
        sample_valid_in && window_sense_in && lower_in != 16'h0000 && upper_in != 16'h0000
        && sample_in > lower_in && sample_in < upper_in |=> cond_out)
        else $error("inside sample missed with sense set");
    chk_single_side: assert property (@(posedge clk_in) disable iff (rst_in)
        sample_valid_in && !window_sense_in && lower_in == 16'h0000 && upper_in != 16'h0000
        |=> cond_out == ($past(sample_in) >= $past(upper_in)))
        else $error("high-only comparison wrong");
endmodule

`default_nettype wire

/* File: src/pwos_regs.sv */
// Pressure window, user offset and signal path status registers.
// Assumes a byte register port from the serial interface, one access per cycle.
// Lock bit, self-test control and stretch setting come from other registers.
`timescale 1ns/1ns
`default_nettype none

module pwos_regs #(
    parameter int REINIT_SAMPLES = pwos_pkg::REINIT_SAMPLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_en_in,
    input wire logic [7:0] reg_wr_data_in,
    input wire logic reg_rd_en_in,
    output logic [7:0] reg_rd_data_out,
    output logic reg_rd_valid_out,
    // Settings held elsewhere
    input wire logic init_done_lock_in,
    input wire logic [1:0] stretch_select_in,
    input wire logic window_sense_in,
    // Self-test control register
    input wire logic [3:0] selftest_control_in,
    input wire logic selftest_control_wr_in,
    input wire logic [3:0] selftest_control_wdata_in,
    // Fault events
    input wire logic common_mode_excursion_in,
    input wire logic selftest_fail_in,
    input wire logic status_tx_clear_in,
    // Calibrated pressure from the signal path
    input wire logic [15:0] calibrated_in,
    input wire logic calibrated_valid_in,
    // Results
    output logic [15:0] sensor_result_out,
    output logic sensor_result_valid_out,
    output logic dsp_path_reset_out,
    output logic array_error_out,
    // Interrupt
    output logic interrupt_out,
    output logic interrupt_event_out
);
    localparam int CW = $clog2(REINIT_SAMPLES + 1);

    // Whole state of the block
    typedef struct packed {
        logic [pwos_pkg::COV_REGS-1:0][7:0] regs;
        logic [pwos_pkg::COV_REGS-1:0] par;
        logic arr_err;
        logic pend;
        logic run;
        logic cmf;
        logic stf;
        logic [7:0] rd_data;
        logic rd_vld;
        logic [15:0] result;
        logic res_vld;
        logic pvld;
        logic dsp_rst;
        logic [CW-1:0] reinit;
        logic irq;
        logic irq_evt;
    } pwos_state_t;

    pwos_state_t s_r;
    pwos_state_t s_nxt;
    logic wr_ok;
    logic ofs_change;
    logic [pwos_pkg::COV_REGS-1:0] mismatch;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] offset;
    logic [7:0] status;
    logic cond;
    logic cond_vld;

    // ------------------------------------------------------------
    // Assembled fields
    // ------------------------------------------------------------
    // low byte at lower address
    assign upper = {s_r.regs[pwos_pkg::IDX_HI_H], s_r.regs[pwos_pkg::IDX_HI_L]};
    assign lower = {s_r.regs[pwos_pkg::IDX_LO_H], s_r.regs[pwos_pkg::IDX_LO_L]};
    assign offset = {s_r.regs[pwos_pkg::IDX_OFS_H], s_r.regs[pwos_pkg::IDX_OFS_L]};

    // Status byte, reserved bits zero
    always_comb begin
        status = 8'h00;
        status[pwos_pkg::STAT_SELFTEST_PENDING] = s_r.pend;
        status[pwos_pkg::STAT_SELFTEST_RUNNING] = s_r.run;
        status[pwos_pkg::STAT_COMMON_MODE_FAULT] = s_r.cmf;
        status[pwos_pkg::STAT_SELFTEST_FAULT] = s_r.stf;
    end

    // ------------------------------------------------------------
    // Array error detection
    // ------------------------------------------------------------
    // threshold and offset bytes checked
    genvar gi;
    generate
        for (gi = 0; gi < pwos_pkg::COV_REGS; gi++) begin : g_par
            assign mismatch[gi] = (^s_r.regs[gi]) != s_r.par[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // Window comparator
    // ------------------------------------------------------------
    // each reported sample judged
    pwos_window_cmp u_cmp (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .sample_in(s_r.result),
        .sample_valid_in(s_r.pvld),
        .upper_in(upper),
        .lower_in(lower),
        .window_sense_in(window_sense_in),
        .cond_out(cond),
        .cond_valid_out(cond_vld)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.dsp_rst = 1'b0;
        s_nxt.irq_evt = 1'b0;
        s_nxt.rd_vld = 1'b0;
        s_nxt.pvld = 1'b0;
        wr_ok = reg_wr_en_in && !init_done_lock_in;
        ofs_change = 1'b0;
        // Byte writes with parity capture
        for (int i = 0; i < pwos_pkg::COV_REGS; i++) begin
            if (wr_ok && reg_addr_in == pwos_pkg::COV_ADDR[i]) begin
                s_nxt.regs[i] = reg_wr_data_in;
                s_nxt.par[i] = ^reg_wr_data_in;
                if ((i == pwos_pkg::IDX_OFS_L || i == pwos_pkg::IDX_OFS_H)
                    && reg_wr_data_in != s_r.regs[i]) begin
                    ofs_change = 1'b1;
                end
            end
        end
        // Sticky array error
        if (|mismatch) begin
            s_nxt.arr_err = 1'b1;
        end
        if (calibrated_valid_in) begin
            s_nxt.result = 16'(calibrated_in + offset);
            s_nxt.pvld = 1'b1;
            if (s_r.reinit != '0) begin
                s_nxt.reinit = CW'(s_r.reinit - 1'b1);
            end
        end
        s_nxt.res_vld = (s_nxt.reinit == '0);
        if (ofs_change) begin
            s_nxt.dsp_rst = 1'b1;
            s_nxt.reinit = CW'(REINIT_SAMPLES);
            s_nxt.res_vld = 1'b0;
        end
        // Register read, data next cycle
        if (reg_rd_en_in) begin
            s_nxt.rd_vld = 1'b1;
            s_nxt.rd_data = 8'h00;
            for (int i = 0; i < pwos_pkg::COV_REGS; i++) begin
                if (reg_addr_in == pwos_pkg::COV_ADDR[i]) begin
                    s_nxt.rd_data = s_r.regs[i];
                end
            end
            if (reg_addr_in == pwos_pkg::SIGNAL_PATH_STATUS_ADDR) begin
                s_nxt.rd_data = status;
            end
        end
        if (selftest_control_wr_in && (|selftest_control_wdata_in)) begin
            s_nxt.pend = 1'b0;
        end
        s_nxt.run = |selftest_control_in;
        if ((reg_rd_en_in && reg_addr_in == pwos_pkg::SIGNAL_PATH_STATUS_ADDR)
            || status_tx_clear_in) begin
            s_nxt.cmf = 1'b0;
        end
        if (common_mode_excursion_in) begin
            s_nxt.cmf = 1'b1;
        end
        if (selftest_fail_in) begin
            s_nxt.stf = 1'b1;
        end
        // Interrupt on each verdict
        if (cond_vld) begin
            if (stretch_select_in == pwos_pkg::STRETCH_NONE) begin
                s_nxt.irq = cond;
            end else begin
                // Stretch timer outside owns the pin
                s_nxt.irq = 1'b0;
                s_nxt.irq_evt = cond;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_r <= '0;
            s_r.pend <= pwos_pkg::PENDING_RESET;
            s_r.res_vld <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rd_data_out = s_r.rd_data;
    assign reg_rd_valid_out = s_r.rd_vld;
    assign sensor_result_out = s_r.result;
    assign sensor_result_valid_out = s_r.res_vld;
    assign dsp_path_reset_out = s_r.dsp_rst;
    assign array_error_out = s_r.arr_err;
    assign interrupt_out = s_r.irq;
    assign interrupt_event_out = s_r.irq_evt;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    chk_lock_holds_regs: assert property (
        init_done_lock_in && reg_wr_en_in |=> $stable(s_r.regs))
        else $error("locked register changed on write");
    chk_offset_restart: assert property (
        reg_wr_en_in && !init_done_lock_in
        && reg_addr_in == 8'h4c && reg_wr_data_in != s_r.regs[4]
        |=> dsp_path_reset_out && !sensor_result_valid_out)
        else $error("offset change did not restart path");
    chk_offset_sum: assert property (
        calibrated_valid_in |=> sensor_result_out == 16'($past(calibrated_in) + $past(offset)))
        else $error("reported pressure not sum of offset");
    chk_pending_reset: assert property (@(posedge clk_in) disable iff (1'b0)
        rst_in |=> status[3] == 1'b1)
        else $error("pending flag not set by reset");
    chk_running_mirror: assert property (
        ##1 1'b1 |-> s_r.run == (|$past(selftest_control_in)))
        else $error("running flag does not follow control");
    chk_cm_set: assert property (
        common_mode_excursion_in |=> status[1])
        else $error("common-mode fault not set");
    chk_cm_clear: assert property (
        reg_rd_en_in && reg_addr_in == 8'h60 && !common_mode_excursion_in |=> !status[1])
        else $error("common-mode fault not cleared by read");
    chk_stfault_sticky: assert property (
        status[0] |=> status[0])
        else $error("self-test fault cleared without reset");
    chk_irq_follows: assert property (
        cond_vld && stretch_select_in == 2'h0 |=> interrupt_out == $past(cond))
        else $error("interrupt pin not following verdict");
    chk_status_read: assert property (
        reg_rd_en_in && reg_addr_in == 8'h60 |=> reg_rd_valid_out && reg_rd_data_out[7:4] == 4'h0)
        else $error("status read answer wrong");

    // Nonzero stretch: pin low, event pulse for the timer
    chk_stretch_quiet: assert property (
        cond_vld && stretch_select_in != 2'h0
        |=> !interrupt_out && interrupt_event_out == $past(cond))
        else $error("pin not handed to stretch timer");
    // Test start clears pending at once
    chk_pending_clear: assert property (
        selftest_control_wr_in && (|selftest_control_wdata_in) |=> !status[3])
        else $error("pending flag not cleared by test start");
    // Only reset may raise pending again
    chk_pending_stays: assert property (
        !status[3] |=> !status[3])
        else $error("pending flag raised without reset");
    // Failed self-test raises the fault
    chk_stfault_set: assert property (
        selftest_fail_in |=> status[0])
        else $error("self-test fault not set");
    // Transmission with the error clears the flag
    chk_cm_tx_clear: assert property (
        status_tx_clear_in && !common_mode_excursion_in |=> !status[1])
        else $error("common-mode fault not cleared by transmit");
    // No valid result while the path restarts
    chk_reinit_invalid: assert property (
        s_r.reinit != '0 |-> !sensor_result_valid_out)
        else $error("result valid during path restart");
    // Locked writes never restart the path
    chk_lock_no_restart: assert property (
        init_done_lock_in |=> !dsp_path_reset_out)
        else $error("locked write restarted path");
    // Every read strobe gets its answer pulse
    chk_read_answer: assert property (
        reg_rd_en_in |=> reg_rd_valid_out)
        else $error("read strobe without answer");
endmodule

`default_nettype wire

/* File: dv/pwos_host_model.sv */
// Host side of the byte register port: one write or read per call.
// Assumes the block answers a read with a one-cycle valid pulse.
`timescale 1ns/1ns
`default_nettype none

module pwos_host_model (
    // Clock
    input wire logic clk_in,
    // Register port
    output logic [7:0] reg_addr_out,
    output logic reg_wr_en_out,
    output logic [7:0] reg_wr_data_out,
    output logic reg_rd_en_out,
    input wire logic [7:0] reg_rd_data_in,
    input wire logic reg_rd_valid_in
);
    // ----------------------------------------
    // Idle port
    // ----------------------------------------
    initial begin
        reg_addr_out = 8'h00;
        reg_wr_en_out = 1'b0;
        reg_wr_data_out = 8'h00;
        reg_rd_en_out = 1'b0;
    end

    // One write strobe, then address and data scrambled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        reg_addr_out = a;
        reg_wr_data_out = d;
        reg_wr_en_out = 1'b1;
        @(posedge clk_in);
        #1;
        reg_wr_en_out = 1'b0;
        reg_addr_out = ~a;
        reg_wr_data_out = ~d;
    endtask

    // One read strobe, data taken with the valid pulse
    // no result reads here
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        d = 8'hxx;
        @(posedge clk_in);
        #1;
        reg_addr_out = a;
        reg_rd_en_out = 1'b1;
        @(posedge clk_in);
        #1;
        reg_rd_en_out = 1'b0;
        reg_addr_out = ~a;
        for (n = 0; n < 4; n++) begin
            if (reg_rd_valid_in === 1'b1) begin
                d = reg_rd_data_in;
                break;
            end
            @(posedge clk_in);
            #1;
        end
    endtask
endmodule

`default_nettype wire

/* File: dv/pressure_window_offset_status_tb_top.sv */
// Testbench of the window, offset and status registers.
// Assumes the host model on the register port; other inputs driven here.
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_count++; \
    $display("FAIL %0t got %h exp %h", $time, got, exp); end end

module pressure_window_offset_status_tb_top;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr, wdata, rdata, d;
    logic wr_en, rd_en, rvalid;
    logic lock = 1'b0;
    logic sense = 1'b0;
    logic [1:0] stretch = 2'h0;
    logic [3:0] selftest_control = 4'h0;
    logic st_wr = 1'b0;
    logic excursion = 1'b0;
    logic st_fail = 1'b0;
    logic tx_clear = 1'b0;
    logic [15:0] cal = 16'h0000;
    logic cal_valid = 1'b0;
    logic [15:0] result;
    logic res_valid, path_reset, arr_err, irq, irq_evt;
    int err_count = 0;
    int checked = 0;

    // Clock of 8 ns
    always #4 clk_in = ~clk_in;

    // ----------------------------------------
    // Instances
    // ----------------------------------------
    pwos_host_model host (.clk_in(clk_in), .reg_addr_out(addr), .reg_wr_en_out(wr_en),
        .reg_wr_data_out(wdata), .reg_rd_en_out(rd_en), .reg_rd_data_in(rdata),
        .reg_rd_valid_in(rvalid));

    pwos_regs #(.REINIT_SAMPLES(2)) dut (.clk_in(clk_in), .rst_in(rst_in),
        .reg_addr_in(addr), .reg_wr_en_in(wr_en), .reg_wr_data_in(wdata),
        .reg_rd_en_in(rd_en), .reg_rd_data_out(rdata), .reg_rd_valid_out(rvalid),
        .init_done_lock_in(lock), .stretch_select_in(stretch), .window_sense_in(sense),
        .selftest_control_in(selftest_control), .selftest_control_wr_in(st_wr),
        .selftest_control_wdata_in(selftest_control), .common_mode_excursion_in(excursion),
        .selftest_fail_in(st_fail), .status_tx_clear_in(tx_clear),
        .calibrated_in(cal), .calibrated_valid_in(cal_valid),
        .sensor_result_out(result), .sensor_result_valid_out(res_valid),
        .dsp_path_reset_out(path_reset), .array_error_out(arr_err),
        .interrupt_out(irq), .interrupt_event_out(irq_evt));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Read one register and compare
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d);
        `CHK(d, e)
    endtask

    // One sample, then the pin three edges later
    task automatic smp(input logic [15:0] v, input logic e);
        @(posedge clk_in);
        #1;
        cal = v;
        cal_valid = 1'b1;
        @(posedge clk_in);
        #1;
        cal_valid = 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        `CHK(irq, e)
    endtask

    // One-cycle pulse on a status event input
    task automatic pulse(ref logic s);
        @(posedge clk_in);
        #1;
        s = 1'b1;
        @(posedge clk_in);
        #1;
        s = 1'b0;
    endtask

    // Verdict and end of run
    task automatic final_report;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog
    initial begin
        #100000;
        err_count++;
        final_report();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        rchk(8'h60, 8'h08); // pending after reset
        rchk(8'h47, 8'h00); // reset value
        rchk(8'h61, 8'h00); // unmapped reads zero
        // Window 0x0800..0x1000
        host.wr(8'h46, 8'h00);
        host.wr(8'h47, 8'h10);
        host.wr(8'h48, 8'h00);
        host.wr(8'h49, 8'h08);
        rchk(8'h49, 8'h08); // byte order
        smp(16'h0900, 1'b0); // inside, outside sense
        smp(16'h1100, 1'b1); // pin follows sample
        `CHK(irq_evt, 1'b0) // no event without stretch
        smp(16'h0800, 1'b1); // boundary is outside
        sense = 1'b1;
        smp(16'h0900, 1'b1); // inside sense
        smp(16'h1100, 1'b0); // outside cleared
        sense = 1'b0;
        // Low side disabled
        host.wr(8'h49, 8'h00);
        smp(16'h0100, 1'b0); // no lower bound
        smp(16'h2000, 1'b1); // upper still active
        // Stretch selected: timer owns the pin
        stretch = 2'h1;
        smp(16'h2000, 1'b0); // pin released to timer
        `CHK(irq_evt, 1'b1) // event for stretch timer
        stretch = 2'h0;
        // Both disabled
        host.wr(8'h47, 8'h00);
        smp(16'h2000, 1'b0); // pin stays off
        sense = 1'b1;
        smp(16'h2000, 1'b0); // either sense
        sense = 1'b0;
        // Lock blocks writes
        lock = 1'b1;
        host.wr(8'h47, 8'h55);
        host.wr(8'h4c, 8'h77);
        rchk(8'h47, 8'h00); // threshold locked
        rchk(8'h4c, 8'h00); // offset locked
        lock = 1'b0;
        // offset of -240 keeps results far from rails
        host.wr(8'h4c, 8'h10);
        `CHK(path_reset, 1'b1) // path reset pulse
        `CHK(res_valid, 1'b0) // results invalid
        host.wr(8'h4d, 8'hff);
        smp(16'h1000, 1'b0);
        `CHK(result, 16'h0f10) // signed offset added
        `CHK(res_valid, 1'b0) // still reinit
        smp(16'h2000, 1'b0);
        `CHK(result, 16'h1f10) // second sample
        repeat (2) @(posedge clk_in);
        #1;
        `CHK(res_valid, 1'b1) // valid after reinit
        `CHK(arr_err, 1'b0) // no array error
        // Status flags
        pulse(excursion);
        rchk(8'h60, 8'h0a); // fault set
        rchk(8'h60, 8'h08); // read clears
        pulse(excursion);
        pulse(tx_clear);
        rchk(8'h60, 8'h08); // transmit clears
        selftest_control = 4'h1;
        pulse(st_wr);
        rchk(8'h60, 8'h04); // pending off, running
        selftest_control = 4'h0;
        rchk(8'h60, 8'h00); // running follows control
        pulse(st_fail);
        rchk(8'h60, 8'h01); // fault set
        rchk(8'h60, 8'h01); // read keeps it
        // Second reset in mid-run
        rst_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        rchk(8'h60, 8'h08); // reset clears fault
        rchk(8'h4d, 8'h00); // reset value again
        final_report();
    end
endmodule

`default_nettype wire
